// >>> common/iis_pkg.sv
package iis_pkg;

    // ************************************************
    // Geometry
    // ************************************************
    localparam int IIS_PIPES = 3;
    localparam int IIS_RS_DEPTH = 8;
    localparam int IIS_ENTRIES = 24;
    localparam int IIS_IDX_W = 5;
    localparam int IIS_TAG_W = 7;
    localparam int IIS_DATA_W = 32;
    localparam int IIS_FLAG_W = 8;
    localparam int IIS_AGE_W = 8;
    localparam logic [IIS_AGE_W-1:0] IIS_AGE_MAX = 8'hff;

    // ************************************************
    // Timing counts, in clock cycles from issue to result bus
    // ************************************************
    localparam int IIS_MUL_LAT_DEF = 3;
    localparam int IIS_CNT_LAT_DEF = 2;

    // ************************************************
    // Encodings
    // ************************************************
    typedef enum logic [3:0] {
        IIS_OP_ADD,
        IIS_OP_SUB,
        IIS_OP_AND,
        IIS_OP_OR,
        IIS_OP_XOR,
        IIS_OP_SETLT,
        IIS_OP_DIVSTEP,
        IIS_OP_FLAGMUX,
        IIS_OP_BRANCH,
        IIS_OP_MUL,
        IIS_OP_LZC,
        IIS_OP_POPC
    } iis_op_e;

    typedef enum logic [1:0] {
        IIS_AGU_LOAD,
        IIS_AGU_STORE,
        IIS_AGU_EACOMP
    } iis_agu_e;

    // ************************************************
    // Entry and pipe stage layouts
    // ************************************************
    typedef struct packed {
        logic rdy;
        logic [IIS_TAG_W-1:0] tag;
        logic [IIS_DATA_W-1:0] val;
    } iis_src_s;

    typedef struct packed {
        logic v;
        logic [IIS_TAG_W-1:0] rob;
        iis_op_e op;
        logic alu_need;
        logic alu_iss;
        logic alu_done;
        logic agu_need;
        logic agu_done;
        iis_agu_e agu_kind;
        logic [IIS_TAG_W-1:0] dst;
        logic [IIS_TAG_W-1:0] dst_hi;
        iis_src_s a;
        iis_src_s b;
        iis_src_s base;
        logic [IIS_DATA_W-1:0] ofs;
        logic [IIS_AGE_W-1:0] age;
    } iis_ent_s;

    typedef struct packed {
        logic v;
        logic [IIS_IDX_W-1:0] idx;
        logic [IIS_TAG_W-1:0] dst;
        logic [IIS_TAG_W-1:0] dst_hi;
        logic [IIS_DATA_W-1:0] lo;
        logic [IIS_DATA_W-1:0] hi;
    } iis_stage_s;

endpackage

// >>> hdl/iis_integer_issue_scheduler.sv
`timescale 1ns/100ps
// Contract
// - Three stations, eight entries each, 24 total
// - Each macro-op splits into ALU/ADDRESS_GENERATION_UNIT micro-ops
// - Three identical pipes, each ALU plus ADDRESS_GENERATION_UNIT
// - Dispatch lane N feeds pipe N
// - Issue only with all source operands ready
// - Micro-ops of one macro-op issue independently
// - Pipe runs ALU and ADDRESS_GENERATION_UNIT op together
// - ALU: logic, arith, conditional, divstep, flags, branch
// - ADDRESS_GENERATION_UNIT computes load, store, effective-address addresses
// - Completion reported once all micro-ops executed
// - Any ALU takes ops except multiply, bitcounts
// - Multiply always issues to pipe 0
// - Multiply result reserves bus slots pipes 0,1
// - Bit counts always issue to pipe 2
// - Bit count result reserves pipe 2 bus slot
module iis_integer_issue_scheduler #(
    parameter int MUL_LAT = iis_pkg::IIS_MUL_LAT_DEF,
    parameter int CNT_LAT = iis_pkg::IIS_CNT_LAT_DEF
) (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Dispatch lanes
    input wire logic [iis_pkg::IIS_PIPES-1:0] disp_valid_i,
    output logic [iis_pkg::IIS_PIPES-1:0] disp_ready_o,
    input wire logic [iis_pkg::IIS_PIPES-1:0][iis_pkg::IIS_TAG_W-1:0] disp_rob_i,
    input wire iis_pkg::iis_op_e [iis_pkg::IIS_PIPES-1:0] disp_op_i,
    input wire logic [iis_pkg::IIS_PIPES-1:0] disp_alu_need_i,
    input wire logic [iis_pkg::IIS_PIPES-1:0] disp_agu_need_i,
    input wire iis_pkg::iis_agu_e [iis_pkg::IIS_PIPES-1:0] disp_agu_kind_i,
    input wire logic [iis_pkg::IIS_PIPES-1:0][iis_pkg::IIS_TAG_W-1:0] disp_dst_i,
    input wire logic [iis_pkg::IIS_PIPES-1:0][iis_pkg::IIS_TAG_W-1:0] disp_dst_hi_i,
    input wire iis_pkg::iis_src_s [iis_pkg::IIS_PIPES-1:0] disp_a_i,
    input wire iis_pkg::iis_src_s [iis_pkg::IIS_PIPES-1:0] disp_b_i,
    input wire iis_pkg::iis_src_s [iis_pkg::IIS_PIPES-1:0] disp_base_i,
    input wire logic [iis_pkg::IIS_PIPES-1:0][iis_pkg::IIS_DATA_W-1:0] disp_ofs_i,
    // Result buses
    output logic [iis_pkg::IIS_PIPES-1:0] rb_valid_o,
    output logic [iis_pkg::IIS_PIPES-1:0][iis_pkg::IIS_TAG_W-1:0] rb_tag_o,
    output logic [iis_pkg::IIS_PIPES-1:0][iis_pkg::IIS_DATA_W-1:0] rb_data_o,
    // Address generation outputs
    output logic [iis_pkg::IIS_PIPES-1:0] agu_valid_o,
    output iis_pkg::iis_agu_e [iis_pkg::IIS_PIPES-1:0] agu_kind_o,
    output logic [iis_pkg::IIS_PIPES-1:0][iis_pkg::IIS_TAG_W-1:0] agu_rob_o,
    output logic [iis_pkg::IIS_PIPES-1:0][iis_pkg::IIS_DATA_W-1:0] agu_addr_o,
    // Branch resolution
    output logic [iis_pkg::IIS_PIPES-1:0] br_valid_o,
    output logic [iis_pkg::IIS_PIPES-1:0] br_taken_o,
    output logic [iis_pkg::IIS_PIPES-1:0][iis_pkg::IIS_TAG_W-1:0] br_rob_o,
    // Completion to dispatch control
    output logic [iis_pkg::IIS_PIPES-1:0] cmp_valid_o,
    output logic [iis_pkg::IIS_PIPES-1:0][iis_pkg::IIS_TAG_W-1:0] cmp_rob_o
);
    import iis_pkg::*;

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        iis_ent_s [IIS_ENTRIES-1:0] ent;
        iis_stage_s [MUL_LAT-2:0] mul;
        iis_stage_s [CNT_LAT-2:0] cnt;
        logic [IIS_PIPES-1:0] rb_v;
        logic [IIS_PIPES-1:0][IIS_TAG_W-1:0] rb_tag;
        logic [IIS_PIPES-1:0][IIS_DATA_W-1:0] rb_data;
        logic [IIS_PIPES-1:0] agu_v;
        iis_agu_e [IIS_PIPES-1:0] agu_kind;
        logic [IIS_PIPES-1:0][IIS_TAG_W-1:0] agu_rob;
        logic [IIS_PIPES-1:0][IIS_DATA_W-1:0] agu_addr;
        logic [IIS_PIPES-1:0] br_v;
        logic [IIS_PIPES-1:0] br_taken;
        logic [IIS_PIPES-1:0][IIS_TAG_W-1:0] br_rob;
        logic [IIS_PIPES-1:0] cmp_v;
        logic [IIS_PIPES-1:0][IIS_TAG_W-1:0] cmp_rob;
    } iis_state_s;

    iis_state_s s;
    iis_state_s next_s;
    logic [1:0] rst_sync;
    logic rst_n;
    logic [IIS_PIPES-1:0] ready_c;

    // ************************************************
    // Helpers
    // ************************************************
    function automatic iis_src_s wake(input iis_src_s src, input logic [IIS_PIPES-1:0] v,
                                      input logic [IIS_PIPES-1:0][IIS_TAG_W-1:0] tag,
                                      input logic [IIS_PIPES-1:0][IIS_DATA_W-1:0] data);
        iis_src_s r;
        r = src;
        for (int k = 0; k < IIS_PIPES; k++) begin
            if (!r.rdy && v[k] && tag[k] == src.tag) begin
                r.rdy = 1'b1;
                r.val = data[k];
            end
        end
        return r;
    endfunction

    // Age ties go to the lower index
    function automatic logic [IIS_IDX_W:0] pick_oldest(input logic [IIS_ENTRIES-1:0] c,
                                                       input logic [IIS_ENTRIES-1:0][IIS_AGE_W-1:0] age);
        logic found;
        logic [IIS_IDX_W-1:0] idx;
        logic [IIS_AGE_W-1:0] best;
        found = 1'b0;
        idx = '0;
        best = '0;
        for (int i = 0; i < IIS_ENTRIES; i++) begin
            if (c[i] && (!found || age[i] > best)) begin
                found = 1'b1;
                idx = IIS_IDX_W'(i);
                best = age[i];
            end
        end
        return {found, idx};
    endfunction

    function automatic logic [IIS_DATA_W-1:0] alu_eval(input iis_op_e op, input logic [IIS_DATA_W-1:0] a,
                                                       input logic [IIS_DATA_W-1:0] b);
        logic [IIS_DATA_W-1:0] r;
        r = '0;
        case (op)
            IIS_OP_ADD: r = a + b;
            IIS_OP_SUB: r = a - b;
            IIS_OP_AND: r = a & b;
            IIS_OP_OR: r = a | b;
            IIS_OP_XOR: r = a ^ b;
            IIS_OP_SETLT: r = IIS_DATA_W'(a < b);
            IIS_OP_DIVSTEP: r = (a >= b) ? a - b : a;
            IIS_OP_FLAGMUX: r = {a[IIS_DATA_W-1:IIS_FLAG_W], b[IIS_FLAG_W-1:0]};
            default: r = '0;
        endcase
        return r;
    endfunction

    function automatic logic [IIS_DATA_W-1:0] bit_count(input iis_op_e op, input logic [IIS_DATA_W-1:0] a);
        logic [IIS_DATA_W-1:0] n;
        logic seen;
        n = '0;
        seen = 1'b0;
        for (int i = IIS_DATA_W - 1; i >= 0; i--) begin
            if (op == IIS_OP_POPC) begin
                n = n + IIS_DATA_W'(a[i]);
            end else if (!seen && !a[i]) begin
                n = n + 1'b1;
            end else begin
                seen = 1'b1;
            end
        end
        return n;
    endfunction

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        logic [IIS_PIPES-1:0][IIS_ENTRIES-1:0] cand_alu;
        logic [IIS_PIPES-1:0][IIS_ENTRIES-1:0] cand_agu;
        logic [IIS_PIPES-1:0][IIS_ENTRIES-1:0] cand_ret;
        logic [IIS_ENTRIES-1:0][IIS_AGE_W-1:0] ages;
        logic [IIS_IDX_W:0] sel;
        logic [IIS_IDX_W-1:0] idx;
        logic [2*IIS_DATA_W-1:0] prod;
        logic mul_block;
        logic cnt_block;
        logic found;
        iis_ent_s e;
        int st;
        int fi;
        next_s = s;
        cand_alu = '0;
        cand_agu = '0;
        cand_ret = '0;
        ages = '0;
        sel = '0;
        idx = '0;
        prod = '0;
        found = 1'b0;
        e = '0;
        st = 0;
        fi = 0;
        ready_c = '0;
        next_s.rb_v = '0;
        next_s.agu_v = '0;
        next_s.br_v = '0;
        next_s.br_taken = '0;
        next_s.cmp_v = '0;
        // Hold ALU ops off a slot a unit result owns
        mul_block = s.mul[MUL_LAT-2].v;
        cnt_block = s.cnt[CNT_LAT-2].v;

        // Wakeup, aging, candidates
        for (int i = 0; i < IIS_ENTRIES; i++) begin
            e = s.ent[i];
            st = i / IIS_RS_DEPTH;
            ages[i] = e.age;
            if (e.v) begin
                next_s.ent[i].a = wake(e.a, s.rb_v, s.rb_tag, s.rb_data);
                next_s.ent[i].b = wake(e.b, s.rb_v, s.rb_tag, s.rb_data);
                next_s.ent[i].base = wake(e.base, s.rb_v, s.rb_tag, s.rb_data);
                if (e.age != IIS_AGE_MAX) begin
                    next_s.ent[i].age = e.age + 1'b1;
                end
            end
            if (e.v && e.alu_need && !e.alu_iss && e.a.rdy && e.b.rdy) begin
                if (e.op == IIS_OP_MUL) begin
                    cand_alu[0][i] = 1'b1;
                end else if (e.op == IIS_OP_LZC || e.op == IIS_OP_POPC) begin
                    cand_alu[2][i] = 1'b1;
                end else if (!(st <= 1 && mul_block) && !(st == 2 && cnt_block)) begin
                    cand_alu[st][i] = 1'b1;
                end
            end
            if (e.v && e.agu_need && !e.agu_done && e.base.rdy) begin
                cand_agu[st][i] = 1'b1;
            end
            if (e.v && (!e.alu_need || e.alu_done) && (!e.agu_need || e.agu_done)) begin
                cand_ret[st][i] = 1'b1;
            end
        end

        // Unit pipelines
        next_s.mul[0] = '0;
        for (int k = 1; k < MUL_LAT - 1; k++) begin
            next_s.mul[k] = s.mul[k-1];
        end
        next_s.cnt[0] = '0;
        for (int k = 1; k < CNT_LAT - 1; k++) begin
            next_s.cnt[k] = s.cnt[k-1];
        end
        if (s.mul[MUL_LAT-2].v) begin
            next_s.rb_v[1:0] = 2'h3;
            next_s.rb_tag[0] = s.mul[MUL_LAT-2].dst;
            next_s.rb_data[0] = s.mul[MUL_LAT-2].lo;
            next_s.rb_tag[1] = s.mul[MUL_LAT-2].dst_hi;
            next_s.rb_data[1] = s.mul[MUL_LAT-2].hi;
            next_s.ent[s.mul[MUL_LAT-2].idx].alu_done = 1'b1;
        end
        if (s.cnt[CNT_LAT-2].v) begin
            next_s.rb_v[2] = 1'b1;
            next_s.rb_tag[2] = s.cnt[CNT_LAT-2].dst;
            next_s.rb_data[2] = s.cnt[CNT_LAT-2].lo;
            next_s.ent[s.cnt[CNT_LAT-2].idx].alu_done = 1'b1;
        end

        // Per-pipe issue and retire
        for (int p = 0; p < IIS_PIPES; p++) begin
            sel = pick_oldest(cand_alu[p], ages);
            if (sel[IIS_IDX_W]) begin
                idx = sel[IIS_IDX_W-1:0];
                e = s.ent[idx];
                next_s.ent[idx].alu_iss = 1'b1;
                case (e.op)
                    IIS_OP_MUL: begin
                        prod = {{IIS_DATA_W{1'b0}}, e.a.val} * {{IIS_DATA_W{1'b0}}, e.b.val};
                        next_s.mul[0].v = 1'b1;
                        next_s.mul[0].idx = idx;
                        next_s.mul[0].dst = e.dst;
                        next_s.mul[0].dst_hi = e.dst_hi;
                        next_s.mul[0].lo = prod[IIS_DATA_W-1:0];
                        next_s.mul[0].hi = prod[2*IIS_DATA_W-1:IIS_DATA_W];
                    end
                    IIS_OP_LZC, IIS_OP_POPC: begin
                        next_s.cnt[0].v = 1'b1;
                        next_s.cnt[0].idx = idx;
                        next_s.cnt[0].dst = e.dst;
                        next_s.cnt[0].lo = bit_count(e.op, e.a.val);
                    end
                    IIS_OP_BRANCH: begin
                        next_s.br_v[p] = 1'b1;
                        next_s.br_taken[p] = (e.a.val == e.b.val);
                        next_s.br_rob[p] = e.rob;
                        next_s.ent[idx].alu_done = 1'b1;
                    end
                    default: begin
                        next_s.rb_v[p] = 1'b1;
                        next_s.rb_tag[p] = e.dst;
                        next_s.rb_data[p] = alu_eval(e.op, e.a.val, e.b.val);
                        next_s.ent[idx].alu_done = 1'b1;
                    end
                endcase
            end
            // ADDRESS_GENERATION_UNIT slot runs beside the ALU slot
            sel = pick_oldest(cand_agu[p], ages);
            if (sel[IIS_IDX_W]) begin
                idx = sel[IIS_IDX_W-1:0];
                next_s.agu_v[p] = 1'b1;
                next_s.agu_kind[p] = s.ent[idx].agu_kind;
                next_s.agu_rob[p] = s.ent[idx].rob;
                next_s.agu_addr[p] = s.ent[idx].base.val + s.ent[idx].ofs;
                next_s.ent[idx].agu_done = 1'b1;
            end
            // One completion per pipe per cycle; extra done entries wait
            sel = pick_oldest(cand_ret[p], ages);
            if (sel[IIS_IDX_W]) begin
                idx = sel[IIS_IDX_W-1:0];
                next_s.cmp_v[p] = 1'b1;
                next_s.cmp_rob[p] = s.ent[idx].rob;
                next_s.ent[idx].v = 1'b0;
            end
            // Lowest free entry of this lane's station
            found = 1'b0;
            fi = 0;
            for (int k = IIS_RS_DEPTH - 1; k >= 0; k--) begin
                if (!s.ent[p*IIS_RS_DEPTH+k].v) begin
                    found = 1'b1;
                    fi = p * IIS_RS_DEPTH + k;
                end
            end
            ready_c[p] = ce_i & found;
            if (disp_valid_i[p] && ready_c[p]) begin
                next_s.ent[fi] = '0;
                next_s.ent[fi].v = 1'b1;
                next_s.ent[fi].rob = disp_rob_i[p];
                next_s.ent[fi].op = disp_op_i[p];
                next_s.ent[fi].alu_need = disp_alu_need_i[p];
                next_s.ent[fi].agu_need = disp_agu_need_i[p];
                next_s.ent[fi].agu_kind = disp_agu_kind_i[p];
                next_s.ent[fi].dst = disp_dst_i[p];
                next_s.ent[fi].dst_hi = disp_dst_hi_i[p];
                next_s.ent[fi].a = wake(disp_a_i[p], s.rb_v, s.rb_tag, s.rb_data);
                next_s.ent[fi].b = wake(disp_b_i[p], s.rb_v, s.rb_tag, s.rb_data);
                next_s.ent[fi].base = wake(disp_base_i[p], s.rb_v, s.rb_tag, s.rb_data);
                next_s.ent[fi].ofs = disp_ofs_i[p];
            end
        end
    end

    // ************************************************
    // Registers
    // ************************************************
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign disp_ready_o = ready_c;
    assign rb_valid_o = s.rb_v;
    assign rb_tag_o = s.rb_tag;
    assign rb_data_o = s.rb_data;
    assign agu_valid_o = s.agu_v;
    assign agu_kind_o = s.agu_kind;
    assign agu_rob_o = s.agu_rob;
    assign agu_addr_o = s.agu_addr;
    assign br_valid_o = s.br_v;
    assign br_taken_o = s.br_taken;
    assign br_rob_o = s.br_rob;
    assign cmp_valid_o = s.cmp_v;
    assign cmp_rob_o = s.cmp_rob;

endmodule

// >>> bench/iis_scheduler_monitor.sv
`timescale 1ns/100ps
// ************************************************
// Scheduler checker
// ************************************************
module iis_scheduler_monitor (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Handshake
    input wire logic [iis_pkg::IIS_PIPES-1:0] disp_valid_i,
    input wire logic [iis_pkg::IIS_PIPES-1:0] disp_ready_o,
    // Strobes
    input wire logic [iis_pkg::IIS_PIPES-1:0] rb_valid_o,
    input wire logic [iis_pkg::IIS_PIPES-1:0] agu_valid_o,
    input wire logic [iis_pkg::IIS_PIPES-1:0] br_valid_o,
    input wire logic [iis_pkg::IIS_PIPES-1:0] cmp_valid_o
);
    // Count lags frees, so never below true fill
    logic [3:0] occ [3];
    logic [2:0] take;
    logic ce_q;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    assign take = disp_valid_i & disp_ready_o & {3{ce_i}};

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            occ <= '{4'h0, 4'h0, 4'h0};
            ce_q <= 1'b0;
        end else begin
            ce_q <= ce_i;
            for (int p = 0; p < 3; p++)
                occ[p] <= occ[p] + {3'h0, take[p]} - {3'h0, cmp_valid_o[p] & ce_q};
        end
    end

    sequence quiet;
        (rb_valid_o | agu_valid_o | br_valid_o | cmp_valid_o) == 3'h0;
    endsequence

    a_quiet_after_reset: assert property ($rose(resetn_i) |-> quiet [*2])
        else $error("Strobe after reset");
    a_ready_gated: assert property (!ce_i |-> disp_ready_o == 3'h0)
        else $error("Ready with enable low");

    for (genvar p = 0; p < 3; p++) begin : g_lane
        sequence take_empty;
            occ[p] == 4'h0 && take[p];
        endsequence
        a_ready_room: assert property (ce_i && occ[p] < 4'h8 |-> disp_ready_o[p])
            else $error("Refused with room");
        a_depth_cap: assert property (occ[p] <= 4'h8)
            else $error("Station overfull");
        a_cmp_owned: assert property (cmp_valid_o[p] && ce_q |-> occ[p] != 4'h0)
            else $error("Orphan completion");
        a_agu_lane: assert property (agu_valid_o[p] |-> occ[p] != 4'h0)
            else $error("Orphan address result");
        a_branch_lane: assert property (br_valid_o[p] |-> occ[p] != 4'h0)
            else $error("Orphan branch result");
        a_no_early_cmp: assert property (take_empty |=> !cmp_valid_o[p])
            else $error("Completion too early");
    end
endmodule

bind iis_integer_issue_scheduler iis_scheduler_monitor mon_u (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce_i), .disp_valid_i(disp_valid_i),
    .disp_ready_o(disp_ready_o), .rb_valid_o(rb_valid_o), .agu_valid_o(agu_valid_o),
    .br_valid_o(br_valid_o), .cmp_valid_o(cmp_valid_o));

// >>> bench/iis_dispatch_model.sv
`timescale 1ns/100ps
// ************************************************
// Dispatch stand-in
// ************************************************
module iis_dispatch_model
    import iis_pkg::*;
(
    // Handshake
    input wire logic clk_sys_i,
    input wire logic [2:0] ready_i,
    // Lanes
    output logic [2:0] valid_o,
    output logic [2:0][6:0] rob_o,
    output iis_op_e [2:0] op_o,
    output logic [2:0] alu_o,
    output logic [2:0] agu_o,
    output iis_agu_e [2:0] kind_o,
    output logic [2:0][6:0] dst_o,
    output logic [2:0][6:0] dhi_o,
    output iis_src_s [2:0] a_o,
    output iis_src_s [2:0] b_o,
    output iis_src_s [2:0] base_o,
    output logic [2:0][31:0] ofs_o
);
    initial begin
        valid_o = 3'h0;
        {rob_o, alu_o, agu_o, dst_o, dhi_o, ofs_o} = '0;
        op_o = {3{IIS_OP_ADD}};
        kind_o = {3{IIS_AGU_LOAD}};
        {a_o, b_o, base_o} = '0;
    end

    // One lane per call
    task automatic send(input int l, input iis_op_e op, input logic [1:0] nd, input iis_agu_e k,
                        input logic [6:0] t, input iis_src_s a, b, bs, input logic [31:0] ofs);
        @(posedge clk_sys_i);
        valid_o[l] <= 1'b1;
        rob_o[l] <= t;
        op_o[l] <= op;
        {agu_o[l], alu_o[l]} <= nd;
        kind_o[l] <= k;
        dst_o[l] <= t;
        dhi_o[l] <= t + 7'h1;
        a_o[l] <= a;
        b_o[l] <= b;
        base_o[l] <= bs;
        ofs_o[l] <= ofs;
        do @(posedge clk_sys_i); while (ready_i[l] !== 1'b1);
        // Released rob, source and offset fields show their inverse
        valid_o[l] <= 1'b0;
        rob_o[l] <= ~t;
        a_o[l] <= ~a;
        b_o[l] <= ~b;
        base_o[l] <= ~bs;
        ofs_o[l] <= ~ofs;
    endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/100ps
// ************************************************
// Testbench
// ************************************************
module testbench;
    import iis_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic [2:0] valid, ready, alu, address_generation_unit, rb_v, ag_v, br_v, br_t, cm_v;
    logic [2:0][6:0] rob, dst, dhi, rb_tag, ag_rob, br_rob, cm_rob;
    logic [2:0][31:0] ofs, rb_data, ag_addr;
    iis_op_e [2:0] op;
    iis_agu_e [2:0] kind, ag_kind;
    iis_src_s [2:0] a, b, base;
    logic [63:0] eq [4][3][$];
    int failures = 0;
    int checked = 0;
    int seed = 3;
    logic [31:0] x, y;

    always #5 clk_sys_i = ~clk_sys_i;

    iis_dispatch_model dm_u (
        .clk_sys_i(clk_sys_i), .ready_i(ready), .valid_o(valid), .rob_o(rob), .op_o(op), .alu_o(alu),
        .agu_o(address_generation_unit), .kind_o(kind), .dst_o(dst), .dhi_o(dhi), .a_o(a), .b_o(b), .base_o(base), .ofs_o(ofs));

    iis_integer_issue_scheduler #(.MUL_LAT(2), .CNT_LAT(3)) dut_u (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce_i), .disp_valid_i(valid), .disp_ready_o(ready),
        .disp_rob_i(rob), .disp_op_i(op), .disp_alu_need_i(alu), .disp_agu_need_i(address_generation_unit), .disp_agu_kind_i(kind),
        .disp_dst_i(dst), .disp_dst_hi_i(dhi), .disp_a_i(a), .disp_b_i(b), .disp_base_i(base), .disp_ofs_i(ofs),
        .rb_valid_o(rb_v), .rb_tag_o(rb_tag), .rb_data_o(rb_data), .agu_valid_o(ag_v), .agu_kind_o(ag_kind),
        .agu_rob_o(ag_rob), .agu_addr_o(ag_addr), .br_valid_o(br_v), .br_taken_o(br_t), .br_rob_o(br_rob),
        .cmp_valid_o(cm_v), .cmp_rob_o(cm_rob));

    function automatic iis_src_s rdy(input logic [31:0] v);
        return '{1'b1, 7'h0, v};
    endfunction

    function automatic logic [31:0] res(input iis_op_e o, input logic [31:0] p, q);
        case (o)
            IIS_OP_ADD: return p + q;
            IIS_OP_SUB: return p - q;
            IIS_OP_AND: return p & q;
            IIS_OP_OR: return p | q;
            IIS_OP_XOR: return p ^ q;
            IIS_OP_SETLT: return {31'h0, p < q};
            IIS_OP_DIVSTEP: return p >= q ? p - q : p;
            IIS_OP_FLAGMUX: return {p[31:8], q[7:0]};
            IIS_OP_POPC: return 32'($countones(p));
            default: begin
                for (int i = 31; i >= 0; i--)
                    if (p[i]) return 32'(31 - i);
                return 32'h20;
            end
        endcase
    endfunction

    function automatic int pending();
        int s;
        s = 0;
        for (int k = 0; k < 4; k++)
            for (int p = 0; p < 3; p++)
                s += eq[k][p].size();
        return s;
    endfunction

    task automatic final_report();
        failures += pending();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Notes results, then offers
    task automatic issue(input int l, input iis_op_e o, input logic [1:0] nd, input iis_agu_e k,
                         input logic [6:0] t, input iis_src_s sa, input logic [31:0] av, bv, bsv, ofv);
        logic [63:0] pr;
        pr = {32'h0, av} * {32'h0, bv};
        if (nd[0] && o == IIS_OP_MUL) begin
            eq[0][0].push_back({25'h0, t, pr[31:0]});
            eq[0][1].push_back({25'h0, t + 7'h1, pr[63:32]});
        end else if (nd[0] && o == IIS_OP_BRANCH) begin
            eq[2][l].push_back({56'h0, t, av == bv});
        end else if (nd[0]) begin
            eq[0][o inside {IIS_OP_LZC, IIS_OP_POPC} ? 2 : l].push_back({25'h0, t, res(o, av, bv)});
        end
        if (nd[1])
            eq[1][l].push_back({23'h0, k, t, bsv + ofv});
        eq[3][l].push_back({57'h0, t});
        dm_u.send(l, o, nd, k, t, sa, rdy(bv), rdy(bsv), ofv);
    endtask

    task automatic chk(input int k, input int p, input logic [63:0] got);
        logic [63:0] exp;
        exp = eq[k][p].size() != 0 ? eq[k][p].pop_front() : 64'hx;
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t kind %0d lane %0d got %h expected %h", $time, k, p, got, exp);
        end
    endtask

    task automatic look(input logic [2:0] got, exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t ready %b expected %b", $time, got, exp);
        end
    endtask

    task automatic drain();
        for (int n = 0; n < 60 && pending() != 0; n++)
            @(posedge clk_sys_i);
        repeat (3) @(posedge clk_sys_i);
    endtask

    always @(posedge clk_sys_i) begin
        for (int p = 0; p < 3; p++) begin
            if (rb_v[p] === 1'b1) chk(0, p, {25'h0, rb_tag[p], rb_data[p]});
            if (ag_v[p] === 1'b1) chk(1, p, {23'h0, ag_kind[p], ag_rob[p], ag_addr[p]});
            if (br_v[p] === 1'b1) chk(2, p, {56'h0, br_rob[p], br_t[p]});
            if (cm_v[p] === 1'b1) chk(3, p, {57'h0, cm_rob[p]});
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        // Each op twice, lanes rotated
        for (int i = 0; i < 24; i++) begin
            x = $random(seed);
            y = i == 8 ? x : $random(seed);
            issue((i + 2 * (i / 12)) % 3, iis_op_e'(i % 12), 2'b01, IIS_AGU_LOAD, 7'(2 * i), rdy(x), x, y, 0, 0);
            drain();
        end
        // Each address kind, each followed by an empty macro-op
        for (int k = 0; k < 3; k++) begin
            x = $random(seed);
            issue(k, IIS_OP_XOR, 2'b11, iis_agu_e'(k), 7'(48 + 2 * k), rdy(x), x, 32'h5a, ~x, 32'hfffffff0);
            issue(k, IIS_OP_ADD, 2'b00, IIS_AGU_LOAD, 7'(56 + k), rdy(x), x, x, 0, 0);
        end
        drain();
        // Three lanes, fixed units from other stations
        fork
            issue(2, IIS_OP_MUL, 2'b01, IIS_AGU_LOAD, 7'h60, rdy(x), x, 32'h3, 0, 0);
            issue(1, IIS_OP_POPC, 2'b01, IIS_AGU_LOAD, 7'h62, rdy(x), x, 0, 0, 0);
            issue(0, IIS_OP_OR, 2'b10, IIS_AGU_STORE, 7'h64, rdy(x), x, 0, 32'h100, 32'h4);
        join
        drain();
        // Eight waiters fill a station, woken together, issued oldest first
        x = $random(seed);
        for (int i = 0; i < 8; i++)
            issue(2, IIS_OP_ADD, 2'b01, IIS_AGU_LOAD, 7'(80 + i), '{1'b0, 7'h70, ~x}, x, 32'(i), 0, 0);
        @(negedge clk_sys_i);
        look({2'h0, ready[2]}, 3'h0);
        issue(0, IIS_OP_ADD, 2'b01, IIS_AGU_LOAD, 7'h70, rdy(x - 32'h9), x - 32'h9, 32'h9, 0, 0);
        drain();
        // Enable low
        @(posedge clk_sys_i) ce_i <= 1'b0;
        @(negedge clk_sys_i);
        look(ready, 3'h0);
        @(posedge clk_sys_i) ce_i <= 1'b1;
        drain();
        final_report();
    end
endmodule
